//--- test_umn_unit.sv
// test_umn_unit: directed scenarios for the multiply/negate unit
// assumes the wide bus variant; the checker is bound at the foot
`timescale 1ns/10ps
module test_umn_unit;
    import umn_pkg::*;
    logic     clk;
    logic     resetn;
    logic     start;
    umn_req_t req;
    logic     busy;
    logic     done;
    logic     illegal;
    umn_rsp_t rsp;
    int       mismatches;
    int       num_checks;
    umn_unit umn_unit_i (.clk(clk), .resetn(resetn), .start(start), .req(req),
        .busy(busy), .done(done), .illegal(illegal), .rsp(rsp));
    // =======================================
    // shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // start in the cycle after the last done, so calls run back to back
    task automatic op(input logic [7:0] opc, input logic [2:0] rf, input logic mem,
                      input logic [15:0] opnd, input logic [15:0] acc, output int n);
        @(posedge clk);
        #1;
        start = 1'b1;
        req = '{opc, rf, mem, opnd, acc, 16'h0700};
        @(posedge clk);
        #1;
        start = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic neg1(input logic [7:0] opc, input logic mem, input logic [15:0] opnd,
                        input logic [15:0] exp, input logic cf, input int clks);
        int n;
        op(opc, REG_NEG, mem, opnd, 16'h1234, n);
        chk(rsp.result_word & (opc == OPC_BYTE ? 16'h00FF : 16'hFFFF), exp);
        chk(rsp.flags_out[FLG_CF], cf);
        chk({rsp.write_operand, rsp.write_accumulator, rsp.write_extension, rsp.byte_size},
            {3'b100, opc == OPC_BYTE});
        chk({rsp.flags_out[10:8], rsp.flags_out[FLG_ZF]}, {3'h7, exp == 16'h0000});
        chk(n, clks - 1);
    endtask
    // =======================================
    // scenarios
    task automatic t_mul_byte();
        int n;
        op(OPC_BYTE, REG_MUL, 1'b0, 16'h77FF, 16'hABFF, n);
        chk(rsp.result_word, 16'hFE01);
        chk({rsp.flags_out[FLG_OF], rsp.flags_out[FLG_CF]}, 2'b11);
        chk(n, MUL_B_REG_CLKS - 1);
        chk({rsp.write_accumulator, rsp.write_extension, rsp.byte_size}, 3'b101);
        op(OPC_BYTE, REG_MUL, 1'b1, 16'h770F, 16'hAB10, n);
        chk(rsp.result_word, 16'h00F0);
        chk({rsp.flags_out[FLG_OF], rsp.flags_out[FLG_CF]}, 2'b00);
        $display("test mul_byte done");
    endtask
    task automatic t_mul_word();
        int n;
        op(OPC_WORD, REG_MUL, 1'b0, 16'hFFFF, 16'hFFFF, n);
        chk({rsp.data_extension_word, rsp.result_word}, 32'hFFFE0001);
        chk(rsp.flags_out[FLG_CF], 1'b1);
        chk({rsp.write_accumulator, rsp.write_extension, rsp.byte_size}, 3'b110);
        op(OPC_WORD, REG_MUL, 1'b1, 16'h0020, 16'h012C, n);
        chk({rsp.data_extension_word, rsp.result_word}, 32'h00002580);
        chk({rsp.flags_out[FLG_OF], rsp.flags_out[FLG_CF]}, 2'b00);
        chk(n, MUL_W_MEM16_CLKS - 1);
        $display("test mul_word done");
    endtask
    task automatic t_neg();
        neg1(OPC_BYTE, 1'b0, 16'h0001, 16'h00FF, 1'b1, NEG_REG_CLKS);
        neg1(OPC_WORD, 1'b1, 16'h0640, 16'hF9C0, 1'b1, NEG_MEM_CLKS);
        neg1(OPC_BYTE, 1'b1, 16'h0000, 16'h0000, 1'b0, NEG_MEM_CLKS);
        neg1(OPC_WORD, 1'b0, 16'h8000, 16'h8000, 1'b1, NEG_REG_CLKS);
        $display("test neg done");
    endtask
    // refusals: unknown reg field, start while busy, reset in mid-run
    task automatic t_refuse();
        @(posedge clk);
        #1;
        start = 1'b1;
        req = '{OPC_WORD, 3'h2, 1'b0, 16'h0005, 16'h0000, 16'h0700};
        @(posedge clk);
        #1;
        chk({illegal, busy, rsp.write_operand, rsp.write_accumulator}, 4'h8);
        req = '{OPC_WORD, REG_NEG, 1'b0, 16'h0005, 16'h0000, 16'h0700};
        @(posedge clk);
        #1;
        // start stays high: this multiply must be ignored while busy
        req = '{OPC_WORD, REG_MUL, 1'b0, 16'h0003, 16'h0003, 16'h0700};
        chk({illegal, busy}, 2'b01);
        @(posedge clk);
        #1;
        start = 1'b0;
        chk({done, rsp.result_word}, {1'b1, 16'hFFFB});
        @(posedge clk);
        #1;
        chk(busy, 1'b0);
        start = 1'b1;
        req = '{OPC_WORD, REG_MUL, 1'b0, 16'h0100, 16'h0100, 16'h0700};
        @(posedge clk);
        #1;
        start = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b0;
        #1;
        chk({busy, done, illegal, rsp.result_word}, 19'h00000);
        chk(rsp.flags_out, 16'h0000);
        @(posedge clk);
        #1;
        resetn = 1'b1;
        neg1(OPC_BYTE, 1'b0, 16'h00FF, 16'h0001, 1'b1, NEG_REG_CLKS);
        $display("test refuse done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // =======================================
    // clock, watchdog, main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    initial begin
        mismatches = 0;
        num_checks = 0;
        resetn = 1'b0;
        start = 1'b0;
        req = '0;
        repeat (2) @(posedge clk);
        #1;
        chk({busy, done, illegal}, 3'b000);
        resetn = 1'b1;
        t_mul_byte();
        t_mul_word();
        t_neg();
        t_refuse();
        conclude();
    end
endmodule
bind umn_unit umn_unit_checker umn_unit_checker_i (.clk(clk), .resetn(resetn), .start(start),
    .req(req), .busy(busy), .done(done), .illegal(illegal), .rsp(rsp));

//--- umn_cycle_timer.sv
// umn_cycle_timer: loadable down-counter that marks the last busy cycle
// assumes load only while idle; single clock domain
`timescale 1ns/10ps
module umn_cycle_timer
    import umn_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_value,
    output logic                  running,
    output logic                  last
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    // ==========================================================
    // next count
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (count != '0) begin
            next_count = count - CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign running = (count != '0);
    assign last    = (count == CNT_W'(1));
endmodule

//--- umn_pkg.sv
// umn_pkg: constants, opcodes and carrier types for the multiply/negate unit
// assumes a decoder upstream that supplies opcode, reg field and operand
package umn_pkg;

    // ==========================================================
    // opcodes and reg-field selectors
    localparam logic [7:0] OPC_BYTE   = 8'hF6;
    localparam logic [7:0] OPC_WORD   = 8'hF7;
    localparam logic [2:0] REG_MUL    = 3'h4;
    localparam logic [2:0] REG_NEG    = 3'h3;

    // ==========================================================
    // cycle counts for negation (total clocks including the start cycle)
    localparam int NEG_REG_CLKS       = 3;
    localparam int NEG_MEM_CLKS       = 10;
    localparam int NEG_MEM_WORD8_CLKS = 14;
    // multiply counts: low bound of the documented ranges
    localparam int MUL_B_REG_CLKS     = 26;
    localparam int MUL_B_MEM_CLKS     = 32;
    localparam int MUL_W_REG_CLKS     = 35;
    localparam int MUL_W_MEM16_CLKS   = 41;
    localparam int MUL_W_MEM8_CLKS    = 45;
    localparam int CNT_W              = 6;

    // ==========================================================
    // flag word bit positions
    localparam int FLG_CF = 0;
    localparam int FLG_PF = 2;
    localparam int FLG_AF = 4;
    localparam int FLG_ZF = 6;
    localparam int FLG_SF = 7;
    localparam int FLG_OF = 11;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [2:0]  reg_field;
        logic        mem_operand;
        logic [15:0] operand;
        logic [15:0] accumulator_word;
        logic [15:0] flags_in;
    } umn_req_t;

    typedef struct packed {
        logic [15:0] result_word;
        logic [15:0] data_extension_word;
        logic        write_accumulator;
        logic        write_extension;
        logic        write_operand;
        logic        byte_size;
        logic [15:0] flags_out;
    } umn_rsp_t;

endpackage

//--- umn_unit.sv
// umn_unit: unsigned multiply and two's complement negate datapath
// assumes start is a one-cycle pulse from the decoder, held off while busy
//
// Overview of operation
// - Multiply treats both factors as unsigned.
// - Byte multiply uses accumulator low byte.
// - Word multiply uses accumulator word, product split.
// - Full double-width product always stored.
// - Carry and overflow set if upper half nonzero.
// - Upper destination half zero when product fits.
// - Negate replaces operand with zero minus operand.
// - Negate carry set iff operand nonzero.
// - Byte negate: 3 clocks register, 10 memory.
// - Word negate: 3 register, 10 or 14 memory.
`timescale 1ns/10ps
module umn_unit
    import umn_pkg::*;
#(
    parameter bit NARROW_BUS = 1'b0   // 1: 8-bit external bus variant
)
(
    input  wire logic     clk,
    input  wire logic     resetn,
    input  wire logic     start,
    input  wire umn_req_t req,
    output logic          busy,
    output logic          done,
    output logic          illegal,
    output umn_rsp_t      rsp
);
    // ==========================================================
    // elaboration check: the timer must hold the longest load value
    localparam int LONGEST_CLKS = (NEG_MEM_WORD8_CLKS > MUL_W_MEM8_CLKS) ?
                                  NEG_MEM_WORD8_CLKS : MUL_W_MEM8_CLKS;
    if (LONGEST_CLKS >= (1 << CNT_W)) begin : g_cnt_check
        $error("cycle counter too narrow");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_RUN} umn_state_t;

    // ==========================================================
    // decode helpers
    function automatic logic is_op(input umn_req_t r, input logic [2:0] sel);
        return ((r.opcode == OPC_BYTE) || (r.opcode == OPC_WORD)) && (r.reg_field == sel);
    endfunction

    function automatic logic parity_even(input logic [7:0] v);
        return ~(^v);
    endfunction

    function automatic logic [CNT_W-1:0] clocks_for(input umn_req_t r, input logic narrow);
        logic wordop;
        wordop = (r.opcode == OPC_WORD);
        if (is_op(r, REG_NEG)) begin
            if (!r.mem_operand) begin
                return CNT_W'(NEG_REG_CLKS - 1);
            end else if (wordop && narrow) begin
                return CNT_W'(NEG_MEM_WORD8_CLKS - 1);
            end else begin
                return CNT_W'(NEG_MEM_CLKS - 1);
            end
        end else if (!wordop) begin
            return r.mem_operand ? CNT_W'(MUL_B_MEM_CLKS - 1) : CNT_W'(MUL_B_REG_CLKS - 1);
        end else if (!r.mem_operand) begin
            return CNT_W'(MUL_W_REG_CLKS - 1);
        end else begin
            return narrow ? CNT_W'(MUL_W_MEM8_CLKS - 1) : CNT_W'(MUL_W_MEM16_CLKS - 1);
        end
    endfunction

    // ==========================================================
    // state and held result
    umn_state_t state;
    umn_state_t next_state;
    umn_rsp_t   next_rsp;
    logic       next_illegal;
    logic       timer_load;
    logic       timer_last;
    logic       accept;

    assign accept     = start && (state == ST_IDLE);
    assign timer_load = accept && (is_op(req, REG_MUL) || is_op(req, REG_NEG));

    // timer paces busy and done only; the answer itself is ready at once
    // the load value is total clocks minus one, since the start cycle
    // already counts as the first clock of the operation
    umn_cycle_timer u_timer (
        .clk        (clk),
        .resetn     (resetn),
        .load       (timer_load),
        .load_value (clocks_for(req, NARROW_BUS)),
        .running    (),
        .last       (timer_last)
    );

    // ==========================================================
    // result computation, captured at the start cycle
    // operands are only valid in the start cycle, so the whole answer is
    // formed then and held in rsp until the next accepted start
    // multiply is a single-cycle array here; the clock counts are kept
    // so software timing loops still see the expected issue rate
    logic [31:0] product;
    logic [15:0] neg_res;
    logic [15:0] neg_half;
    logic        byte_op;
    logic        upper_nz;
    logic        neg_nz;
    logic [15:0] fl;
    logic        neg_zf;
    logic        neg_sf;
    logic        neg_pf;
    logic        neg_af;
    logic        neg_of;

    // ==========================================================
    // negate flags, as for a subtraction from zero
    // kept apart from the result mux so the width choice is made once
    always_comb begin
        neg_zf = ~neg_nz;
        neg_sf = byte_op ? neg_res[7] : neg_res[15];
        neg_pf = parity_even(neg_res[7:0]);
        // borrow out of bit 3 whenever the low nibble is nonzero
        neg_af = (req.operand[3:0] != 4'h0) && neg_half[4];
        neg_of = byte_op ? (req.operand[7:0] == 8'h80)
                         : (req.operand == 16'h8000);
    end

    // ==========================================================
    // result mux and multiply flags
    always_comb begin
        byte_op  = (req.opcode == OPC_BYTE);
        fl       = req.flags_in;
        next_rsp = rsp;
        next_illegal = 1'b0;
        // unsigned zero-extended factors, no sign extension
        if (byte_op) begin
            product = {16'h0000, 8'h00, req.operand[7:0]} * {24'h000000,
                      req.accumulator_word[7:0]};
            upper_nz = (product[15:8] != 8'h00);
            neg_res  = {8'h00, 8'h00 - req.operand[7:0]};
            neg_nz   = (req.operand[7:0] != 8'h00);
        end else begin
            product  = {16'h0000, req.operand} * {16'h0000, req.accumulator_word};
            upper_nz = (product[31:16] != 16'h0000);
            neg_res  = 16'h0000 - req.operand;
            neg_nz   = (req.operand != 16'h0000);
        end
        neg_half = 16'h0000 - {12'h000, req.operand[3:0]};
        if (accept) begin
            next_rsp.byte_size  = byte_op;
            next_rsp.write_accumulator = 1'b0;
            next_rsp.write_extension   = 1'b0;
            next_rsp.write_operand     = 1'b0;
            if (is_op(req, REG_MUL)) begin
                // full product kept: upper half is nonzero exactly when CF and OF are set
                next_rsp.result_word = byte_op ? product[15:0] : product[15:0];
                next_rsp.data_extension_word = byte_op ? 16'h0000 : product[31:16];
                next_rsp.write_accumulator = 1'b1;
                next_rsp.write_extension   = ~byte_op;
                fl[FLG_CF] = upper_nz;
                fl[FLG_OF] = upper_nz;
            end else if (is_op(req, REG_NEG)) begin
                next_rsp.result_word = neg_res;
                next_rsp.data_extension_word = 16'h0000;
                next_rsp.write_operand = 1'b1;
                fl[FLG_CF] = neg_nz;
                // as subtraction from zero
                fl[FLG_ZF] = neg_zf;
                fl[FLG_SF] = neg_sf;
                fl[FLG_PF] = neg_pf;
                fl[FLG_AF] = neg_af;
                fl[FLG_OF] = neg_of;
            end else begin
                next_illegal = 1'b1;   // not ours: flag it, write nothing
            end
            next_rsp.flags_out = fl;   // direction, interrupt, trap pass through
        end
    end

    // ==========================================================
    // sequencing
    // busy covers cycles 1 to N-1 and done marks cycle N-1, so a new start
    // is legal in cycle N and back-to-back issue has no gap
    // limitation: a start that arrives while busy is dropped without any
    // signal, so the decoder must hold off on busy itself
    // an unsupported request never leaves idle; it pulses illegal and clears the write strobes in rsp
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (timer_load) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (timer_last) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // reset clears the held response so no stale write strobe survives
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state   <= ST_IDLE;
            rsp     <= '0;
            illegal <= 1'b0;
        end else begin
            state   <= next_state;
            rsp     <= next_rsp;
            illegal <= next_illegal;
        end
    end

    assign busy = (state == ST_RUN);
    assign done = (state == ST_RUN) && timer_last;
endmodule

//--- umn_unit_checker.sv
// umn_unit_checker: port-level assertions for the multiply/negate unit
// assumes the wide bus variant, one clock domain, bound from the bench
`timescale 1ns/10ps
module umn_unit_checker
    import umn_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     resetn,
    input  wire logic     start,
    input  wire umn_req_t req,
    input  wire logic     busy,
    input  wire logic     done,
    input  wire logic     illegal,
    input  wire umn_rsp_t rsp
);
    // =======================================
    // decode of an accepted request
    wire logic take = start && !busy;
    wire logic tm_b = take && req.opcode == OPC_BYTE && req.reg_field == REG_MUL;
    wire logic tm_w = take && req.opcode == OPC_WORD && req.reg_field == REG_MUL;
    wire logic tn_b = take && req.opcode == OPC_BYTE && req.reg_field == REG_NEG;
    wire logic tn_w = take && req.opcode == OPC_WORD && req.reg_field == REG_NEG;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // =======================================
    // negate timing: register form checks busy window then a single done; memory form only done, 9 cycles after start
    sequence s_neg_reg;
        ##1 busy ##1 (busy && done) ##1 !busy;
    endsequence
    sequence s_neg_mem;
        ##1 (!done)[*8] ##1 done;
    endsequence
    property p_neg_reg; (tn_b || tn_w) && !req.mem_operand |-> s_neg_reg; endproperty
    a_neg_reg: assert property (p_neg_reg) else $error("register negate length wrong");
    property p_neg_mem; (tn_b || tn_w) && req.mem_operand |-> s_neg_mem; endproperty
    a_neg_mem: assert property (p_neg_mem) else $error("memory negate length wrong");
    // =======================================
    // products and flags, valid one cycle after the start
    property p_mul_w;
        tm_w |=> {rsp.data_extension_word, rsp.result_word}
            == $past(req.operand) * $past(req.accumulator_word);
    endproperty
    a_mul_w: assert property (p_mul_w) else $error("word product wrong");
    property p_mul_b;
        tm_b |=> rsp.result_word == $past(req.operand[7:0]) * $past(req.accumulator_word[7:0]);
    endproperty
    a_mul_b: assert property (p_mul_b) else $error("byte product wrong");
    property p_mul_fl;
        tm_w |=> rsp.flags_out[FLG_CF] == (rsp.data_extension_word != 16'h0000)
            && rsp.flags_out[FLG_OF] == rsp.flags_out[FLG_CF];
    endproperty
    a_mul_fl: assert property (p_mul_fl) else $error("multiply flags wrong");
    property p_fit; tm_b |=> rsp.flags_out[FLG_CF] == (rsp.result_word[15:8] != 8'h00); endproperty
    a_fit: assert property (p_fit) else $error("byte high half not tied to carry");
    property p_neg_w;
        tn_w |=> rsp.result_word == 16'h0000 - $past(req.operand) && rsp.write_operand;
    endproperty
    a_neg_w: assert property (p_neg_w) else $error("word negate result wrong");
    property p_neg_cf; tn_b |=> rsp.flags_out[FLG_CF] == ($past(req.operand[7:0]) != 8'h00); endproperty
    a_neg_cf: assert property (p_neg_cf) else $error("negate carry wrong");
    property p_keep; tn_b || tn_w |=> rsp.flags_out[10:8] == $past(req.flags_in[10:8]); endproperty
    a_keep: assert property (p_keep) else $error("control flags disturbed");
    property p_refuse;
        take && !(tm_b || tm_w || tn_b || tn_w) |=> illegal && !busy && !rsp.write_operand;
    endproperty
    a_refuse: assert property (p_refuse) else $error("unsupported request not refused");
endmodule
